// ==== pkg/shp_pkg.sv ====
package shp_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_DIR_A   = 8'h00;
	localparam logic [7:0] OFS_OUT_A   = 8'h04;
	localparam logic [7:0] OFS_PULL_A  = 8'h08;
	localparam logic [7:0] OFS_WAKE_A  = 8'h0c;
	localparam logic [7:0] OFS_OD_A    = 8'h10;
	localparam logic [7:0] OFS_PIN_A   = 8'h14;
	localparam logic [7:0] OFS_DIR_B   = 8'h18;
	localparam logic [7:0] OFS_OUT_B   = 8'h1c;
	localparam logic [7:0] OFS_PULL_B  = 8'h20;
	localparam logic [7:0] OFS_ADC_B   = 8'h24;
	localparam logic [7:0] OFS_PIN_B   = 8'h28;
	localparam logic [7:0] OFS_DIR_D   = 8'h2c;
	localparam logic [7:0] OFS_OUT_D   = 8'h30;
	localparam logic [7:0] OFS_PULL_D  = 8'h34;
	localparam logic [7:0] OFS_PWM_D   = 8'h38;
	localparam logic [7:0] OFS_PIN_D   = 8'h3c;

	// Reset values: all pins input, latches, pulls and selects cleared
	localparam logic [7:0] RST_DIR     = 8'hff;
	localparam logic [7:0] RST_CLR     = 8'h00;
	localparam logic [3:0] RST_NIB     = 4'h0;

	// Masks of implemented bits
	localparam logic [7:0] MASK_FULL   = 8'hff;
	localparam logic [7:0] MASK_PB6    = 8'h3f;
	localparam logic [7:0] MASK_NO_PD7 = 8'h7f;
	localparam logic [3:0] MASK_PWM4   = 4'hf;
	localparam logic [3:0] MASK_PWM3   = 4'h7;

	// Field positions of shared pins
	localparam int BIT_BZ      = 0;
	localparam int BIT_BZ_N    = 1;
	localparam int BIT_PFD     = 3;
	localparam int BIT_PA_TMR  = 4;
	localparam int BIT_IRQ0    = 4;
	localparam int BIT_IRQ1    = 5;
	localparam int BIT_TIMER0_INPUT    = 6;
	localparam int BIT_TIMER1_INPUT    = 7;

	// Port A pin 4 shared function
	typedef enum logic [1:0] {
		PA4_NONE = 2'b00,
		PA4_TIMER1_INPUT = 2'b01,
		PA4_TIMER2_INPUT = 2'b10
	} shp_pa4_e;
endpackage : shp_pkg

// ==== rtl/shp_sync.sv ====
`timescale 1ns/100ps
module shp_sync #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);
	logic [W-1:0] meta_ff;

	// Two-stage synchroniser, first stage read only by the second
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta_ff <= '0;
			syncOut <= '0;
		end else begin
			meta_ff <= asyncIn;
			syncOut <= meta_ff;
		end
	end
endmodule : shp_sync

// ==== rtl/shp_pad_ctrl.sv ====
`timescale 1ns/100ps
module shp_pad_ctrl #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] dirIn,
	input  wire logic [W-1:0] outLatch,
	input  wire logic [W-1:0] altEn,
	input  wire logic [W-1:0] altVal,
	input  wire logic [W-1:0] odEn,
	input  wire logic [W-1:0] padOff,
	output logic      [W-1:0] nxt_padOut,
	output logic      [W-1:0] nxt_padOeN
);
	logic [W-1:0] val;
	logic [W-1:0] drive;

	always_comb begin
		// Shared function overrides latch and direction
		val   = (altVal & altEn) | (outLatch & ~altEn);
		drive = (altEn | ~dirIn) & ~padOff;
		// Open drain releases the pin on a high level
		drive = drive & ~(odEn & val);
		nxt_padOut = val & drive;
		nxt_padOeN = ~drive;
	end
endmodule : shp_pad_ctrl

// ==== rtl/shp_gpio_top.sv ====
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
// Contract
// R1 - Each port_a bit has its own wake-up enable bit in wake_enable_reg.
// R2 - Per-pin direction bit chooses CMOS output drive or Schmitt input.
// R3 - Each pin has its own pull-high enable in its port pullup register.
// R4 - Option-selected buzzer, inverted buzzer, divider output on port_a 0,1,3.
// R5 - Port_a pins 0 to 3 may be open-drain via open_drain_ctrl_reg.
// R6 - Analog-selected port_b pin loses digital I/O and pull-high.
// R7 - Port_d pins 0 to 3 carry pulse outputs when selected.
// R8 - Port_d pins 4 to 7 feed irq0, irq1, timer0, timer1; pin 7 feeds nothing if PA4_FN is PA4_TIMER1_INPUT.
// R9 - Port_a pin 4 feeds timer1, timer2 or nothing by variant.
// R10 - Small variant: six analog pins, three pulse outputs, no port_d 7.
// R11 - A shared function owning a pin sets its output value.
module shp_gpio_top #(
	parameter int              PB_PINS = 8,
	parameter int              PWM_CH  = 4,
	parameter bit              PD7_EN  = 1'b1,
	parameter shp_pkg::shp_pa4_e PA4_FN = shp_pkg::PA4_TIMER2_INPUT,
	parameter bit              BZ_OPT  = 1'b0,
	parameter bit              PFD_OPT = 1'b0
) (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        buzzerOut,
	input  wire logic        freqDividerOut,
	input  wire logic [3:0]  pulseOutputs,
	input  wire logic [7:0]  padAIn,
	output logic      [7:0]  padAOut,
	output logic      [7:0]  padAOeN,
	output logic      [7:0]  pullEnA,
	input  wire logic [7:0]  padBIn,
	output logic      [7:0]  padBOut,
	output logic      [7:0]  padBOeN,
	output logic      [7:0]  pullEnB,
	input  wire logic [7:0]  padDIn,
	output logic      [7:0]  padDOut,
	output logic      [7:0]  padDOeN,
	output logic      [7:0]  pullEnD,
	output logic      [7:0]  adcSenseEn,
	output logic             extIrq0,
	output logic             extIrq1,
	output logic             timer0Input,
	output logic             timer1Input,
	output logic             timer2Input,
	output logic             wakeReq
);
	// Implemented-bit masks by variant [R10]
	localparam logic [7:0] MASK_B = (PB_PINS == 8) ?
		shp_pkg::MASK_FULL : shp_pkg::MASK_PB6;
	localparam logic [7:0] MASK_D = PD7_EN ?
		shp_pkg::MASK_FULL : shp_pkg::MASK_NO_PD7;
	localparam logic [3:0] MASK_P = (PWM_CH == 4) ?
		shp_pkg::MASK_PWM4 : shp_pkg::MASK_PWM3;

	if (PB_PINS != 6 && PB_PINS != 8) begin : gBadPb
		$error("PB_PINS must be 6 or 8");
	end
	if (PWM_CH != 3 && PWM_CH != 4) begin : gBadPwm
		$error("PWM_CH must be 3 or 4");
	end

	logic [7:0] dirA_ff, outA_ff, pullA_ff, wakeA_ff;
	logic [3:0] odA_ff;
	logic [7:0] dirB_ff, outB_ff, pullB_ff, adcB_ff;
	logic [7:0] dirD_ff, outD_ff, pullD_ff;
	logic [3:0] pwmD_ff;
	logic [7:0] syncA, syncB, syncD;
	logic [7:0] prevA_ff;
	logic [7:0] pinB, pinD;
	logic       setup;
	logic       wrEn;
	logic [7:0] wdata;
	logic [31:0] nxt_prdata;
	logic       nxt_pslverr;
	logic [7:0] altEnA, altValA, odEnA;
	logic [7:0] altEnD, altValD;
	logic [7:0] nxt_aOut, nxt_aOeN;
	logic [7:0] nxt_bOut, nxt_bOeN;
	logic [7:0] nxt_dOut, nxt_dOeN;

	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	assign setup = psel & ~penable;
	assign wrEn  = psel & penable & pready & pwrite;
	assign wdata = pwdata[7:0];

	// Pin inputs pass two flip-flops
	shp_sync #(.W(8)) uSyncA (
		.mclk    (mclk),
		.rstn    (rstn),
		.asyncIn (padAIn),
		.syncOut (syncA)
	);
	shp_sync #(.W(8)) uSyncB (
		.mclk    (mclk),
		.rstn    (rstn),
		.asyncIn (padBIn),
		.syncOut (syncB)
	);
	shp_sync #(.W(8)) uSyncD (
		.mclk    (mclk),
		.rstn    (rstn),
		.asyncIn (padDIn),
		.syncOut (syncD)
	);

	// Analog-selected pins read as zero digitally [R6]
	assign pinB = syncB & ~adcB_ff & MASK_B;
	assign pinD = syncD & MASK_D;

	// Port A registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dirA_ff  <= shp_pkg::RST_DIR;
			outA_ff  <= shp_pkg::RST_CLR;
			pullA_ff <= shp_pkg::RST_CLR;
			wakeA_ff <= shp_pkg::RST_CLR;
			odA_ff   <= shp_pkg::RST_NIB;
		end else if (wrEn) begin
			if (hit(paddr, shp_pkg::OFS_DIR_A)) begin
				dirA_ff <= wdata; // [R2]
			end else if (hit(paddr, shp_pkg::OFS_OUT_A)) begin
				outA_ff <= wdata;
			end else if (hit(paddr, shp_pkg::OFS_PULL_A)) begin
				pullA_ff <= wdata; // [R3]
			end else if (hit(paddr, shp_pkg::OFS_WAKE_A)) begin
				wakeA_ff <= wdata; // [R1]
			end else if (hit(paddr, shp_pkg::OFS_OD_A)) begin
				odA_ff <= wdata[3:0]; // [R5]
			end
		end
	end

	// Port B registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dirB_ff  <= shp_pkg::RST_DIR;
			outB_ff  <= shp_pkg::RST_CLR;
			pullB_ff <= shp_pkg::RST_CLR;
			adcB_ff  <= shp_pkg::RST_CLR;
		end else if (wrEn) begin
			if (hit(paddr, shp_pkg::OFS_DIR_B)) begin
				dirB_ff <= wdata | ~MASK_B; // [R2] [R10]
			end else if (hit(paddr, shp_pkg::OFS_OUT_B)) begin
				outB_ff <= wdata & MASK_B;
			end else if (hit(paddr, shp_pkg::OFS_PULL_B)) begin
				pullB_ff <= wdata & MASK_B; // [R3]
			end else if (hit(paddr, shp_pkg::OFS_ADC_B)) begin
				adcB_ff <= wdata & MASK_B; // [R6] [R10]
			end
		end
	end

	// Port D registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dirD_ff  <= shp_pkg::RST_DIR;
			outD_ff  <= shp_pkg::RST_CLR;
			pullD_ff <= shp_pkg::RST_CLR;
			pwmD_ff  <= shp_pkg::RST_NIB;
		end else if (wrEn) begin
			if (hit(paddr, shp_pkg::OFS_DIR_D)) begin
				dirD_ff <= wdata | ~MASK_D; // [R2] [R10]
			end else if (hit(paddr, shp_pkg::OFS_OUT_D)) begin
				outD_ff <= wdata & MASK_D;
			end else if (hit(paddr, shp_pkg::OFS_PULL_D)) begin
				pullD_ff <= wdata & MASK_D; // [R3]
			end else if (hit(paddr, shp_pkg::OFS_PWM_D)) begin
				pwmD_ff <= wdata[3:0] & MASK_P; // [R7] [R10]
			end
		end
	end

	// Read mux, evaluated in the setup cycle
	always_comb begin
		nxt_prdata  = '0;
		nxt_pslverr = 1'b0;
		if (hit(paddr, shp_pkg::OFS_DIR_A)) begin
			nxt_prdata[7:0] = dirA_ff;
		end else if (hit(paddr, shp_pkg::OFS_OUT_A)) begin
			nxt_prdata[7:0] = outA_ff;
		end else if (hit(paddr, shp_pkg::OFS_PULL_A)) begin
			nxt_prdata[7:0] = pullA_ff;
		end else if (hit(paddr, shp_pkg::OFS_WAKE_A)) begin
			nxt_prdata[7:0] = wakeA_ff;
		end else if (hit(paddr, shp_pkg::OFS_OD_A)) begin
			nxt_prdata[3:0] = odA_ff;
		end else if (hit(paddr, shp_pkg::OFS_PIN_A)) begin
			nxt_prdata[7:0] = syncA;
		end else if (hit(paddr, shp_pkg::OFS_DIR_B)) begin
			nxt_prdata[7:0] = dirB_ff & MASK_B;
		end else if (hit(paddr, shp_pkg::OFS_OUT_B)) begin
			nxt_prdata[7:0] = outB_ff;
		end else if (hit(paddr, shp_pkg::OFS_PULL_B)) begin
			nxt_prdata[7:0] = pullB_ff;
		end else if (hit(paddr, shp_pkg::OFS_ADC_B)) begin
			nxt_prdata[7:0] = adcB_ff;
		end else if (hit(paddr, shp_pkg::OFS_PIN_B)) begin
			nxt_prdata[7:0] = pinB;
		end else if (hit(paddr, shp_pkg::OFS_DIR_D)) begin
			nxt_prdata[7:0] = dirD_ff & MASK_D;
		end else if (hit(paddr, shp_pkg::OFS_OUT_D)) begin
			nxt_prdata[7:0] = outD_ff;
		end else if (hit(paddr, shp_pkg::OFS_PULL_D)) begin
			nxt_prdata[7:0] = pullD_ff;
		end else if (hit(paddr, shp_pkg::OFS_PWM_D)) begin
			nxt_prdata[3:0] = pwmD_ff;
		end else if (hit(paddr, shp_pkg::OFS_PIN_D)) begin
			nxt_prdata[7:0] = pinD;
		end else begin
			nxt_pslverr = 1'b1;
		end
	end

	// One wait-free access phase per transfer
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			if (setup) begin
				prdata  <= nxt_prdata;
				pslverr <= nxt_pslverr;
			end else begin
				prdata  <= '0;
				pslverr <= 1'b0;
			end
		end
	end

	// Shared-function ownership of port A and port D pins
	always_comb begin
		altEnA  = '0;
		altValA = '0;
		odEnA   = '0;
		altEnD  = '0;
		altValD = '0;
		altEnA[shp_pkg::BIT_BZ]    = BZ_OPT; // [R4]
		altValA[shp_pkg::BIT_BZ]   = buzzerOut; // [R11]
		altEnA[shp_pkg::BIT_BZ_N]  = BZ_OPT; // [R4]
		altValA[shp_pkg::BIT_BZ_N] = ~buzzerOut; // [R11]
		altEnA[shp_pkg::BIT_PFD]   = PFD_OPT; // [R4]
		altValA[shp_pkg::BIT_PFD]  = freqDividerOut; // [R11]
		odEnA[3:0]  = odA_ff; // [R5]
		altEnD[3:0]  = pwmD_ff; // [R7]
		altValD[3:0] = pulseOutputs & MASK_P; // [R11]
	end

	shp_pad_ctrl #(.W(8)) uPadA (
		.dirIn      (dirA_ff),
		.outLatch   (outA_ff),
		.altEn      (altEnA),
		.altVal     (altValA),
		.odEn       (odEnA),
		.padOff     (8'h00),
		.nxt_padOut (nxt_aOut),
		.nxt_padOeN (nxt_aOeN)
	);
	shp_pad_ctrl #(.W(8)) uPadB (
		.dirIn      (dirB_ff),
		.outLatch   (outB_ff),
		.altEn      (8'h00),
		.altVal     (8'h00),
		.odEn       (8'h00),
		.padOff     (adcB_ff | ~MASK_B), // [R6]
		.nxt_padOut (nxt_bOut),
		.nxt_padOeN (nxt_bOeN)
	);
	shp_pad_ctrl #(.W(8)) uPadD (
		.dirIn      (dirD_ff),
		.outLatch   (outD_ff),
		.altEn      (altEnD),
		.altVal     (altValD),
		.odEn       (8'h00),
		.padOff     (~MASK_D), // [R10]
		.nxt_padOut (nxt_dOut),
		.nxt_padOeN (nxt_dOeN)
	);

	// Registered pad drive and pull-high enables
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			padAOut    <= '0;
			padAOeN    <= '1;
			padBOut    <= '0;
			padBOeN    <= '1;
			padDOut    <= '0;
			padDOeN    <= '1;
			pullEnA    <= '0;
			pullEnB    <= '0;
			pullEnD    <= '0;
			adcSenseEn <= '0;
		end else begin
			padAOut    <= nxt_aOut; // [R2]
			padAOeN    <= nxt_aOeN; // [R2]
			padBOut    <= nxt_bOut;
			padBOeN    <= nxt_bOeN;
			padDOut    <= nxt_dOut;
			padDOeN    <= nxt_dOeN;
			pullEnA    <= pullA_ff; // [R3]
			pullEnB    <= pullB_ff & ~adcB_ff; // [R3] [R6]
			pullEnD    <= pullD_ff; // [R3]
			adcSenseEn <= adcB_ff; // [R6]
		end
	end

	// Routed inputs and wake-up on an enabled falling edge
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			prevA_ff    <= '1;
			wakeReq     <= 1'b0;
			extIrq0     <= 1'b0;
			extIrq1     <= 1'b0;
			timer0Input <= 1'b0;
			timer1Input <= 1'b0;
			timer2Input <= 1'b0;
		end else begin
			prevA_ff    <= syncA;
			wakeReq     <= |(wakeA_ff & prevA_ff & ~syncA); // [R1]
			extIrq0     <= pinD[shp_pkg::BIT_IRQ0]; // [R8]
			extIrq1     <= pinD[shp_pkg::BIT_IRQ1]; // [R8]
			timer0Input <= pinD[shp_pkg::BIT_TIMER0_INPUT]; // [R8]
			if (PA4_FN == shp_pkg::PA4_TIMER1_INPUT) begin
				timer1Input <= syncA[shp_pkg::BIT_PA_TMR]; // [R9]
			end else begin
				timer1Input <= pinD[shp_pkg::BIT_TIMER1_INPUT]; // [R8]
			end
			timer2Input <= (PA4_FN == shp_pkg::PA4_TIMER2_INPUT) &
				syncA[shp_pkg::BIT_PA_TMR]; // [R9]
		end
	end
endmodule : shp_gpio_top

// ==== testbench/shp_gpio_sva.sv ====
`timescale 1ns/100ps
module shp_gpio_sva #(
	parameter bit BZ_OPT  = 1'b0,
	parameter bit PFD_OPT = 1'b0
) (
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        buzzerOut,
	input wire logic        freqDividerOut,
	input wire logic [7:0]  padAOut,
	input wire logic [7:0]  padAOeN,
	input wire logic [7:0]  padBOeN,
	input wire logic [7:0]  pullEnB,
	input wire logic [7:0]  padDIn,
	input wire logic [7:0]  adcSenseEn,
	input wire logic        extIrq0,
	input wire logic        extIrq1,
	input wire logic        timer0Input,
	input wire logic        timer1Input
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	// Edges since reset release, saturating
	logic [1:0] upCnt_ff;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			upCnt_ff <= 2'h0;
		else if (upCnt_ff != 2'h3)
			upCnt_ff <= upCnt_ff + 2'h1;
	end

	sequence setupPh;
		psel && !penable;
	endsequence
	sequence accessPh;
		psel && penable && pready;
	endsequence

	apb_answer_a: assert property (setupPh |=> accessPh)
		else $error("no answer after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	buzzer_drive_a: assert property (BZ_OPT && $past(rstn) |->
		padAOut[0] == $past(buzzerOut) && !padAOeN[0])
		else $error("buzzer not on pin 0");
	buzzer_inv_a: assert property (BZ_OPT && $past(rstn) |->
		padAOut[1] == !$past(buzzerOut) && !padAOeN[1])
		else $error("inverted buzzer not on pin 1");
	pfd_drive_a: assert property (PFD_OPT && $past(rstn) |->
		padAOut[3] == $past(freqDividerOut) && !padAOeN[3])
		else $error("divider output not on pin 3");
	adc_release_a: assert property ($past(rstn) |->
		(adcSenseEn & $past(adcSenseEn) & (pullEnB | ~padBOeN)) == 8'h00)
		else $error("analog pin driven or pulled");
	irq_route_a: assert property (upCnt_ff == 2'h3 |->
		{extIrq1, extIrq0} == $past(padDIn[5:4], 3))
		else $error("irq inputs not routed");
	timer_route_a: assert property (upCnt_ff == 2'h3 |->
		{timer1Input, timer0Input} == $past(padDIn[7:6], 3))
		else $error("timer inputs not routed");
endmodule : shp_gpio_sva

// ==== testbench/shp_pin_model.sv ====
`timescale 1ns/100ps
module shp_pin_model (
	input  wire logic       mclk,
	input  wire logic [7:0] padOut,
	input  wire logic [7:0] padOeN,
	input  wire logic [7:0] pullEn,
	input  wire logic [7:0] extVal,
	input  wire logic [7:0] extEn,
	output logic      [7:0] padIn
);
	logic [7:0] prev_ff = 8'h00;
	always @(posedge mclk)
		prev_ff <= padIn;
	// Undriven, unpulled pin wanders every cycle
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!padOeN[i])
				padIn[i] = padOut[i];
			else if (extEn[i])
				padIn[i] = extVal[i];
			else if (pullEn[i])
				padIn[i] = 1'b1;
			else
				padIn[i] = ~prev_ff[i];
		end
	end
endmodule : shp_pin_model

// ==== testbench/tb_shp_gpio_top.sv ====
`timescale 1ns/100ps
module tb_shp_gpio_top;
	logic        mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, pready, pslverr, wakeReq;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, seed = 32'h3b;
	logic        buzzerOut = 1'b0, freqDividerOut = 1'b0;
	logic [3:0]  pulseOutputs = 4'h0;
	logic [7:0]  padAIn, padAOut, padAOeN, pullEnA, extValA = 8'h00;
	logic [7:0]  padBIn, padBOut, padBOeN, pullEnB, extValB = 8'h00;
	logic [7:0]  padDIn, padDOut, padDOeN, pullEnD, extValD = 8'h00;
	logic [7:0]  extEnA = 8'h00, extEnB = 8'h00, extEnD = 8'h00, adcSenseEn;
	logic        extIrq0, extIrq1, timer0Input, timer1Input, timer2Input;
	int          error_cnt = 0, n_checks = 0;

	shp_gpio_top #(.BZ_OPT(1'b1), .PFD_OPT(1'b1)) DUT (.*);
	shp_pin_model pmA (.mclk(mclk), .padOut(padAOut), .padOeN(padAOeN),
		.pullEn(pullEnA), .extVal(extValA), .extEn(extEnA), .padIn(padAIn));
	shp_pin_model pmB (.mclk(mclk), .padOut(padBOut), .padOeN(padBOeN),
		.pullEn(pullEnB), .extVal(extValB), .extEn(extEnB), .padIn(padBIn));
	shp_pin_model pmD (.mclk(mclk), .padOut(padDOut), .padOeN(padDOeN),
		.pullEn(pullEnD), .extVal(extValD), .extEn(extEnD), .padIn(padDIn));

	always #12.5 mclk = ~mclk;
	always @(posedge mclk)
		{freqDividerOut, buzzerOut} <= {freqDividerOut, buzzerOut} + 2'h1;

	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			error_cnt++;
			summarize();
		end
	endtask : apb

	task automatic wr(input logic [7:0] a, d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	initial begin
		logic [31:0] r, n;
		logic        e;
		logic [7:0]  v, d;
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		apb(1'b0, shp_pkg::OFS_DIR_A, 8'h00, r, e);
		chk("dirA", r, 32'hff);
		apb(1'b0, 8'h40, 8'h00, r, e);
		chk("badErr", e, 1'b1);
		chk("badData", r, 32'h0);
		extEnA <= 8'hff;
		extValA <= 8'hff;
		wr(shp_pkg::OFS_WAKE_A, 8'h20);
		extValA <= 8'h9f;
		n = 0;
		repeat (8) begin
			@(posedge mclk);
			n = n + wakeReq;
		end
		chk("wake", n, 32'h1);
		chk("timer2_input", timer2Input, 1'b1);
		apb(1'b0, shp_pkg::OFS_PIN_A, 8'h00, r, e);
		chk("pinA", r & 32'hf4, 32'h94);
		wr(shp_pkg::OFS_DIR_A, 8'h00);
		wr(shp_pkg::OFS_OD_A, 8'h04);
		wr(shp_pkg::OFS_OUT_A, 8'h24);
		repeat (2) @(posedge mclk);
		chk("odHi", {padAOeN[5], padAOeN[2], padAOeN[0]}, 3'b010);
		wr(shp_pkg::OFS_OUT_A, 8'h00);
		repeat (2) @(posedge mclk);
		chk("odLo", {padAOeN[2], padAOut[2]}, 2'b00);
		v = rnd();
		wr(shp_pkg::OFS_PULL_A, v);
		repeat (2) @(posedge mclk);
		chk("pullA", pullEnA, v);
		apb(1'b0, shp_pkg::OFS_PULL_A, 8'h00, r, e);
		chk("pullARd", r, v);
		apb(1'b0, shp_pkg::OFS_WAKE_A, 8'h00, r, e);
		chk("wakeRd", r, 32'h20);
		apb(1'b0, shp_pkg::OFS_OD_A, 8'h00, r, e);
		chk("odRd", r, 32'h4);
		extEnD <= 8'hff;
		for (int k = 0; k < 6; k++) begin
			d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : rnd();
			v = rnd();
			extValD <= rnd();
			wr(shp_pkg::OFS_DIR_D, d);
			wr(shp_pkg::OFS_OUT_D, v);
			wr(shp_pkg::OFS_PULL_D, v ^ d);
			repeat (2) @(posedge mclk);
			chk("oeD", padDOeN, d);
			chk("outD", padDOut & ~d, v & ~d);
			chk("pullD", pullEnD, v ^ d);
			apb(1'b0, shp_pkg::OFS_PIN_D, 8'h00, r, e);
			v = (d & extValD) | (~d & v);
			chk("pinD", r, v);
			chk("rt", {timer1Input, timer0Input, extIrq1, extIrq0}, v[7:4]);
		end
		d = rnd();
		n = rnd();
		wr(shp_pkg::OFS_PULL_B, 8'hff);
		wr(shp_pkg::OFS_DIR_B, 8'h00);
		wr(shp_pkg::OFS_OUT_B, n[7:0]);
		wr(shp_pkg::OFS_ADC_B, d);
		repeat (2) @(posedge mclk);
		v = ~d;
		chk("adc", adcSenseEn, d);
		chk("adcPull", pullEnB, v);
		chk("adcOe", padBOeN, d);
		chk("adcOut", padBOut, n[7:0] & v);
		apb(1'b0, shp_pkg::OFS_PIN_B, 8'h00, r, e);
		chk("adcPin", r & d, 32'h0);
		chk("pinB", r, n[7:0] & v);
		wr(shp_pkg::OFS_DIR_D, 8'hff);
		wr(shp_pkg::OFS_PWM_D, 8'h0f);
		repeat (3) begin
			v = rnd();
			pulseOutputs <= v[3:0];
			repeat (3) @(posedge mclk);
			chk("pwm", {padDOeN[3:0], padDOut[3:0]}, {4'h0, v[3:0]});
		end
		// Mid-run reset puts pins back to released inputs
		rstn <= 1'b0;
		@(posedge mclk);
		chk("rstOe", {padAOeN, padDOeN}, 16'hffff);
		chk("rstAdc", {pullEnB, adcSenseEn}, 16'h0000);
		rstn <= 1'b1;
		apb(1'b0, shp_pkg::OFS_PWM_D, 8'h00, r, e);
		chk("rstPwm", r, 32'h0);
		apb(1'b0, shp_pkg::OFS_DIR_B, 8'h00, r, e);
		chk("rstDirB", r, 32'hff);
		summarize();
	end
endmodule : tb_shp_gpio_top

bind shp_gpio_top shp_gpio_sva #(.BZ_OPT(BZ_OPT), .PFD_OPT(PFD_OPT)) chk_i (.*);
